// ---- usbp_consts.svh ----
// Offsets, field positions, reset values and timing counts of the dual-role port status block
//
// Contract
// - Long-SE0 status bit is 1 after more than 2 ms of SE0, else 0.
// - Remote-connect status bit follows detection of the far end's pull-up.
// - Remote pull-up detection starts 50 us after the local pull-up is switched off.
// - In B role, B-session-ok bit follows the B session-valid comparator.
// - In A role, A-session-ok bit follows the A session-valid comparator.
// - In B role, B-session-over bit is 1 while supply is below session-end threshold.
// - In A role, A-supply-ok bit follows the A supply-valid comparator.
// - Identification status bit mirrors the identification pin level.
// - Status register is read-only at code 67h; host never writes it.
// - Event register is read at code 68h and written at code E8h.
// - Port timer time-out sets the timer event bit.
// - SE0 lasting more than 2 ms sets the SE0 request event bit.
// - Remote session request, by supply or data-line pulsing per select bit, sets event.
// - J-to-K transition while suspended sets the resume event bit.
// - Event bits stay set until written with 1; writing 0 leaves them.
// - Bus idle for more than 3 ms sets the suspend event bit.
// - Each status bit 0 to 5 changing sets its change event bit.
`ifndef USBP_CONSTS_SVH
`define USBP_CONSTS_SVH

// Command codes; byte address is four times the code
`define USBP_CODE_STATUS_RD   9'h067
`define USBP_CODE_EVENT_RD    9'h068
`define USBP_CODE_EVENT_WR    9'h0E8
`define USBP_CODE_CTRL        9'h080
`define USBP_CODE_IRQ_MASK    9'h081
`define USBP_CODE_IRQ_STATUS  9'h082

// Status fields
`define USBP_ST_IDENT         0
`define USBP_ST_A_SUPPLY      1
`define USBP_ST_B_OVER        2
`define USBP_ST_A_SESS        3
`define USBP_ST_B_SESS        4
`define USBP_ST_REMOTE        5
`define USBP_ST_LONG_SE0      9
`define USBP_ST_MASK          16'h023F
`define USBP_ST_RESET         16'h0005

// Event fields
`define USBP_EV_TIMER         10
`define USBP_EV_SE0_REQ       9
`define USBP_EV_SRP           8
`define USBP_EV_RESUME        7
`define USBP_EV_SUSPEND       6
`define USBP_EV_MASK          16'h07FF
`define USBP_EV_RESET         16'h0000

// Control fields
`define USBP_CT_KIND_SEL      9
`define USBP_CT_LOCAL_PU      0
`define USBP_CT_MASK          16'h0201
`define USBP_CT_RESET         16'h0000

// Timing
`define USBP_CLK_MHZ          125
`define USBP_SE0_TIME_MS      2
`define USBP_IDLE_TIME_MS     3
`define USBP_PU_WAIT_US       50
`define USBP_SE0_CYCLES       (`USBP_SE0_TIME_MS * 1000 * `USBP_CLK_MHZ)
`define USBP_IDLE_CYCLES      (`USBP_IDLE_TIME_MS * 1000 * `USBP_CLK_MHZ)
`define USBP_PU_CYCLES        (`USBP_PU_WAIT_US * `USBP_CLK_MHZ)
`define USBP_CNT_W            19

`endif

// ---- usbp_far_end.sv ----
// Far-end model: remote line states and the remote pull-up
`timescale 1ns/1ps
`default_nettype none
module usbp_far_end (
   input  wire logic       mclk,
   input  wire logic [1:0] line_req,
   input  wire logic       pullup_req,
   output logic            dp,
   output logic            dm,
   output logic            remote_pullup_sense
);
   initial begin
      dp = 1'b1;
      dm = 1'b0;
      remote_pullup_sense = 1'b0;
   end
   // Line moves only after an edge, as a transceiver would
   always @(posedge mclk) begin
      case (line_req)
         2'h1: begin
            dp <= 1'b0;
            dm <= 1'b1;
         end
         2'h2: begin
            dp <= 1'b0;
            dm <= 1'b0;
         end
         default: begin
            dp <= 1'b1;
            dm <= 1'b0;
         end
      endcase
      remote_pullup_sense <= pullup_req;
   end
endmodule
`default_nettype wire

// ---- usbp_linemon.sv ----
// Line state monitor: long SE0, idle suspend and resume detection
`timescale 1ns/1ps
`default_nettype none
`include "usbp_consts.svh"
module usbp_linemon
   import usbp_pkg::*;
#(
   parameter logic [18:0] SE0_CYCLES  = 19'(`USBP_SE0_CYCLES),
   parameter logic [18:0] IDLE_CYCLES = 19'(`USBP_IDLE_CYCLES)
)
(
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic dp,
   input  wire logic dm,
   output logic      long_se0,
   output logic      suspended,
   output logic      resume
);

   usbp_line_t s;
   usbp_line_t next_s;
   logic       is_se0;
   logic       is_j;
   logic       is_k;

   always_comb begin
      is_se0 = !dp && !dm;
      is_j   = dp && !dm;
      is_k   = !dp && dm;
      next_s = s;
      next_s.was_j = is_j;
      // Counters saturate so a stuck bus cannot wrap the flag off
      if (!is_se0) begin
         next_s.se0_cnt = 19'h00000;
      end else if (s.se0_cnt != SE0_CYCLES) begin
         next_s.se0_cnt = 19'(s.se0_cnt + 19'h00001);
      end
      if (!is_j) begin
         next_s.idle_cnt = 19'h00000;
      end else if (s.idle_cnt != IDLE_CYCLES) begin
         next_s.idle_cnt = 19'(s.idle_cnt + 19'h00001);
      end
      next_s.long_se0 = is_se0 && (s.se0_cnt == SE0_CYCLES);
      next_s.resume   = s.suspended && s.was_j && is_k;
      if (is_j && s.idle_cnt == IDLE_CYCLES) begin
         next_s.suspended = 1'b1;
      end else if (!is_j) begin
         next_s.suspended = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign long_se0  = s.long_se0;
   assign suspended = s.suspended;
   assign resume    = s.resume;

endmodule
`default_nettype wire

// ---- usbp_pkg.sv ----
// Types of the dual-role port status block
package usbp_pkg;

   typedef enum logic [0:0] {
      USBP_BUS_IDLE,
      USBP_BUS_ANSWER
   } usbp_bus_t;

   typedef struct packed {
      logic [18:0] se0_cnt;
      logic [18:0] idle_cnt;
      logic        long_se0;
      logic        suspended;
      logic        resume;
      logic        was_j;
   } usbp_line_t;

   typedef struct packed {
      usbp_bus_t   phase;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic [15:0] status;
      logic [15:0] evt;
      logic [15:0] ctrl;
      logic [15:0] mask;
      logic [15:0] irq_st;
      logic        irq;
      logic        local_pu;
      logic [18:0] pu_cnt;
      logic        det_en;
      logic        prev_se0;
      logic        prev_susp;
      logic        prev_a_sess;
      logic        prev_dp;
   } usbp_top_t;

endpackage

// ---- usbp_port_status.sv ----
// Dual-role port status and event flag registers behind an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "usbp_consts.svh"
module usbp_port_status
   import usbp_pkg::*;
#(
   parameter logic [18:0] SE0_CYCLES  = 19'(`USBP_SE0_CYCLES),
   parameter logic [18:0] IDLE_CYCLES = 19'(`USBP_IDLE_CYCLES),
   parameter logic [18:0] PU_CYCLES   = 19'(`USBP_PU_CYCLES)
)
(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        plug_ident_pin,
   input  wire logic        b_session_ok_threshold,
   input  wire logic        a_session_ok_threshold,
   input  wire logic        b_session_over_threshold,
   input  wire logic        a_supply_ok_threshold,
   input  wire logic        remote_pullup_sense,
   input  wire logic        dp_pin,
   input  wire logic        dm_pin,
   input  wire logic        port_timer_timeout,
   output logic             local_pullup_on
);

   usbp_top_t   s;
   usbp_top_t   next_s;
   logic [8:0]  raw_in;
   logic [8:0]  syn;
   logic        lm_long_se0;
   logic        lm_suspended;
   logic        lm_resume;
   logic        access;
   logic        wr_done;
   logic        rd_done;
   logic [15:0] set_evt;
   logic [15:0] wclr;
   logic [15:0] chg;
   logic        srp;

   default clocking cb_chk @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   function automatic logic [11:0] code_addr(input logic [8:0] c);
      code_addr = {1'b0, c, 2'b00};
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [8:0] c);
      hit = (a == code_addr(c));
   endfunction

   assign raw_in = {dm_pin, dp_pin, remote_pullup_sense, a_supply_ok_threshold,
                    b_session_over_threshold, a_session_ok_threshold,
                    b_session_ok_threshold, 1'b0, plug_ident_pin};

   usbp_sync u_sync (
      .mclk    (mclk),
      .rstn    (rstn),
      .d_async (raw_in),
      .d_sync  (syn)
   );

   usbp_linemon #(
      .SE0_CYCLES  (SE0_CYCLES),
      .IDLE_CYCLES (IDLE_CYCLES)
   ) u_linemon (
      .mclk      (mclk),
      .rstn      (rstn),
      .dp        (syn[7]),
      .dm        (syn[8]),
      .long_se0  (lm_long_se0),
      .suspended (lm_suspended),
      .resume    (lm_resume)
   );

   always_comb begin
      next_s  = s;
      access  = psel && penable;
      wr_done = access && s.pready && pwrite;
      rd_done = access && s.pready && !pwrite;

      // Status view; the role gates keep the idle role's bits at zero
      next_s.status = 16'h0000;
      next_s.status[`USBP_ST_IDENT]    = syn[0];
      next_s.status[`USBP_ST_B_SESS]   = syn[0] && syn[2];
      next_s.status[`USBP_ST_A_SESS]   = !syn[0] && syn[3];
      next_s.status[`USBP_ST_B_OVER]   = syn[0] && syn[4];
      next_s.status[`USBP_ST_A_SUPPLY] = !syn[0] && syn[5];
      next_s.status[`USBP_ST_LONG_SE0] = lm_long_se0;
      // Remote bit holds its last value while detection is blind
      next_s.status[`USBP_ST_REMOTE]   = s.det_en ? syn[6] : s.status[`USBP_ST_REMOTE];

      // Detection waits for the local pull-up to bleed off
      next_s.local_pu = s.ctrl[`USBP_CT_LOCAL_PU];
      if (s.local_pu) begin
         next_s.pu_cnt = 19'h00000;
         next_s.det_en = 1'b0;
      end else if (s.pu_cnt != PU_CYCLES) begin
         next_s.pu_cnt = 19'(s.pu_cnt + 19'h00001);
         next_s.det_en = 1'b0;
      end else begin
         next_s.det_en = 1'b1;
      end

      // Session request: supply pulse or data-line pulse, A role only
      next_s.prev_a_sess = syn[3];
      next_s.prev_dp     = syn[7];
      next_s.prev_se0    = lm_long_se0;
      next_s.prev_susp   = lm_suspended;
      if (s.ctrl[`USBP_CT_KIND_SEL]) begin
         srp = !syn[0] && syn[3] && !s.prev_a_sess;
      end else begin
         srp = !syn[0] && syn[7] && !s.prev_dp;
      end

      chg     = next_s.status ^ s.status;
      set_evt = 16'h0000;
      set_evt[`USBP_EV_TIMER]   = port_timer_timeout;
      set_evt[`USBP_EV_SE0_REQ] = lm_long_se0 && !s.prev_se0;
      set_evt[`USBP_EV_SRP]     = srp;
      set_evt[`USBP_EV_RESUME]  = lm_resume;
      set_evt[`USBP_EV_SUSPEND] = lm_suspended && !s.prev_susp;
      set_evt[5:0]              = chg[5:0];

      // Write-one-to-clear; a new event in the same cycle wins
      wclr = 16'h0000;
      if (wr_done && hit(paddr, `USBP_CODE_EVENT_WR)) begin
         wclr = pwdata[15:0] & `USBP_EV_MASK;
      end
      next_s.evt = ((s.evt & ~wclr) | set_evt) & `USBP_EV_MASK;

      // Interrupt status clears on its own read; an event in the clearing cycle is kept, one in the cycle the data was taken is lost
      if (rd_done && hit(paddr, `USBP_CODE_IRQ_STATUS)) begin
         next_s.irq_st = set_evt;
      end else begin
         next_s.irq_st = s.irq_st | set_evt;
      end
      next_s.irq = |(next_s.irq_st & s.mask);

      if (wr_done && hit(paddr, `USBP_CODE_CTRL)) begin
         next_s.ctrl = pwdata[15:0] & `USBP_CT_MASK;
      end
      if (wr_done && hit(paddr, `USBP_CODE_IRQ_MASK)) begin
         next_s.mask = pwdata[15:0] & `USBP_EV_MASK;
      end

      // APB: answer on the second access cycle with registered data
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      case (s.phase)
         USBP_BUS_IDLE: begin
            if (access) begin
               next_s.pready = 1'b1;
               next_s.phase  = USBP_BUS_ANSWER;
               next_s.prdata = 32'h00000000;
               if (!pwrite && hit(paddr, `USBP_CODE_STATUS_RD)) begin
                  next_s.prdata = {16'h0000, s.status};
               end else if (!pwrite && hit(paddr, `USBP_CODE_EVENT_RD)) begin
                  next_s.prdata = {16'h0000, s.evt};
               end else if (hit(paddr, `USBP_CODE_CTRL)) begin
                  next_s.prdata = {16'h0000, s.ctrl};
               end else if (hit(paddr, `USBP_CODE_IRQ_MASK)) begin
                  next_s.prdata = {16'h0000, s.mask};
               end else if (!pwrite && hit(paddr, `USBP_CODE_IRQ_STATUS)) begin
                  next_s.prdata = {16'h0000, s.irq_st};
               end else if (!(pwrite && hit(paddr, `USBP_CODE_EVENT_WR))) begin
                  // Status is read-only: a write to it is refused too
                  next_s.pslverr = 1'b1;
               end
            end
         end
         USBP_BUS_ANSWER: begin
            next_s.phase = USBP_BUS_IDLE;
         end
         default: begin
            next_s.phase = USBP_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s             <= '0;
         s.phase       <= USBP_BUS_IDLE;
         s.status      <= `USBP_ST_RESET;
         s.evt         <= `USBP_EV_RESET;
         s.ctrl        <= `USBP_CT_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign prdata          = s.prdata;
   assign pready          = s.pready;
   assign pslverr         = s.pslverr;
   assign irq             = s.irq;
   assign local_pullup_on = s.local_pu;

   a_long_se0_flag: assert property (@(posedge mclk) disable iff (!rstn)
      s.status[`USBP_ST_LONG_SE0] == $past(lm_long_se0))
      else $error("long SE0 status does not follow line monitor");

   a_b_role_gate: assert property (@(posedge mclk) disable iff (!rstn)
      $past(syn[0]) |-> (s.status[`USBP_ST_B_SESS] == $past(syn[2])
                         && s.status[`USBP_ST_B_OVER] == $past(syn[4])
                         && !s.status[`USBP_ST_A_SESS] && !s.status[`USBP_ST_A_SUPPLY]))
      else $error("B role status bits wrong");

   a_a_role_gate: assert property (@(posedge mclk) disable iff (!rstn)
      !$past(syn[0]) |-> (s.status[`USBP_ST_A_SESS] == $past(syn[3])
                          && s.status[`USBP_ST_A_SUPPLY] == $past(syn[5])
                          && !s.status[`USBP_ST_B_SESS] && !s.status[`USBP_ST_B_OVER]))
      else $error("A role status bits wrong");

   a_ident_mirror: assert property (@(posedge mclk) disable iff (!rstn)
      s.status[`USBP_ST_IDENT] == $past(syn[0]))
      else $error("ident status does not mirror pin");

   a_pullup_wait: assert property (@(posedge mclk) disable iff (!rstn)
      $fell(s.local_pu) |-> !s.det_en [*8])
      else $error("remote detection enabled too early");

   a_change_flag: assert property (@(posedge mclk) disable iff (!rstn)
      (chg[5:0] != 6'h00) |=> ((s.evt[5:0] & $past(chg[5:0])) == $past(chg[5:0])))
      else $error("status change not latched");

   a_w1c_hold: assert property (@(posedge mclk) disable iff (!rstn)
      1'b1 |=> ((s.evt & $past(s.evt & ~wclr)) == $past(s.evt & ~wclr)))
      else $error("event bit lost without write of one");

   a_timer_event: assert property (@(posedge mclk) disable iff (!rstn)
      port_timer_timeout |=> s.evt[`USBP_EV_TIMER])
      else $error("timer event not set");

   a_resume_event: assert property (@(posedge mclk) disable iff (!rstn)
      lm_resume |=> s.evt[`USBP_EV_RESUME])
      else $error("resume event not set");

   a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
      ((s.status & ~`USBP_ST_MASK) == 16'h0000) && ((s.evt & ~`USBP_EV_MASK) == 16'h0000))
      else $error("reserved bit set");

   a_status_read: assert property (@(posedge mclk) disable iff (!rstn)
      (access && !s.pready && !pwrite && hit(paddr, `USBP_CODE_STATUS_RD))
      |=> (s.pready && prdata == {16'h0000, $past(s.status)}))
      else $error("status read answer wrong");

   a_se0_request: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(lm_long_se0) |=> s.evt[`USBP_EV_SE0_REQ])
      else $error("SE0 request event not set");

   a_remote_follow: assert property (
      $past(s.det_en) |-> (s.status[`USBP_ST_REMOTE] == $past(syn[6])))
      else $error("remote status does not follow its input");

   a_remote_hold: assert property (
      !$past(s.det_en) |-> $stable(s.status[`USBP_ST_REMOTE]))
      else $error("remote status moved while detection blind");

   a_detect_count: assert property (
      s.det_en |-> (s.pu_cnt == PU_CYCLES))
      else $error("detection on before full wait");

   a_detect_blind: assert property (
      s.local_pu |=> !s.det_en)
      else $error("detection on with local pull-up on");

   a_pullup_copy: assert property (
      local_pullup_on == $past(s.ctrl[`USBP_CT_LOCAL_PU]))
      else $error("local pull-up does not follow control");

   a_status_ro: assert property (
      (wr_done && hit(paddr, `USBP_CODE_STATUS_RD)) |-> s.pslverr)
      else $error("status write not refused");

   a_event_read: assert property (
      (access && !s.pready && !pwrite && hit(paddr, `USBP_CODE_EVENT_RD))
      |=> (s.pready && prdata == {16'h0000, $past(s.evt)}))
      else $error("event read answer wrong");

   a_event_wr_only: assert property (
      (rd_done && hit(paddr, `USBP_CODE_EVENT_WR)) |-> s.pslverr)
      else $error("read of event write code not refused");

   a_srp_event: assert property (
      srp |=> s.evt[`USBP_EV_SRP])
      else $error("session request event not set");

   a_resume_gate: assert property (
      lm_resume |-> $past(lm_suspended))
      else $error("resume seen outside suspend");

   a_event_clear: assert property (
      (wr_done && hit(paddr, `USBP_CODE_EVENT_WR)) |=> ((s.evt & $past(wclr & ~set_evt)) == 16'h0000))
      else $error("write of one did not clear event");

   a_set_wins: assert property (
      1'b1 |=> ((s.evt & $past(set_evt)) == $past(set_evt)))
      else $error("new event lost");

   a_suspend_event: assert property (
      $rose(lm_suspended) |=> s.evt[`USBP_EV_SUSPEND])
      else $error("suspend event not set");

   a_change_only: assert property (
      (chg[5:0] == 6'h00 && wclr[5:0] == 6'h00) |=> (s.evt[5:0] == $past(s.evt[5:0])))
      else $error("change event moved without cause");

   a_upper_zero: assert property (
      s.pready |-> (prdata[31:16] == 16'h0000))
      else $error("upper read data not zero");

   a_ctrl_reserved: assert property (
      (s.ctrl & ~`USBP_CT_MASK) == 16'h0000)
      else $error("reserved control bit set");

   a_pready_pulse: assert property (
      s.pready |=> !s.pready)
      else $error("ready longer than one cycle");

   a_err_with_ready: assert property (
      s.pslverr |-> s.pready)
      else $error("error without ready");

   a_err_no_data: assert property (
      s.pslverr |-> (prdata == 32'h00000000))
      else $error("refused access returned data");

   a_irq_level: assert property (
      s.irq == |(s.irq_st & $past(s.mask)))
      else $error("interrupt level wrong");

   c_resume_seen:   cover property (@(posedge mclk) disable iff (!rstn) lm_resume);
   c_irq_raised:    cover property (@(posedge mclk) disable iff (!rstn) $rose(s.irq));
   c_event_cleared: cover property (@(posedge mclk) disable iff (!rstn) (wclr != 16'h0000));
   c_detect_on:     cover property (@(posedge mclk) disable iff (!rstn) $rose(s.det_en));
   c_suspend_seen:  cover property (@(posedge mclk) disable iff (!rstn) $rose(lm_suspended));

endmodule
`default_nettype wire

// ---- usbp_port_status_bench.sv ----
// Self-checking bench of the dual-role port status block
`timescale 1ns/1ps
`default_nettype none
`include "usbp_consts.svh"
module usbp_port_status_bench;
   localparam logic [11:0] A_ST = {1'b0, `USBP_CODE_STATUS_RD, 2'b00};
   localparam logic [11:0] A_ER = {1'b0, `USBP_CODE_EVENT_RD, 2'b00};
   localparam logic [11:0] A_EW = {1'b0, `USBP_CODE_EVENT_WR, 2'b00};
   localparam logic [11:0] A_CT = {1'b0, `USBP_CODE_CTRL, 2'b00};
   localparam logic [11:0] A_MK = {1'b0, `USBP_CODE_IRQ_MASK, 2'b00};
   localparam logic [11:0] A_IS = {1'b0, `USBP_CODE_IRQ_STATUS, 2'b00};
   logic        mclk, rstn, psel, penable, pwrite, tmo, pu_on, irq, pready, pslverr, dp, dm, rsense, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, w, d;
   logic [31:0] seed = 32'h0000_0033;
   logic [5:0]  stim, chg;
   logic [1:0]  line_req;
   logic [15:0] prev, cur;
   int          checks, n_fail, i;

   usbp_port_status #(.SE0_CYCLES(19'd40), .IDLE_CYCLES(19'd60), .PU_CYCLES(19'd20)) uut (
      .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .plug_ident_pin(stim[0]), .a_supply_ok_threshold(stim[1]), .b_session_over_threshold(stim[2]),
      .a_session_ok_threshold(stim[3]), .b_session_ok_threshold(stim[4]), .remote_pullup_sense(rsense),
      .dp_pin(dp), .dm_pin(dm), .port_timer_timeout(tmo), .local_pullup_on(pu_on));
   usbp_far_end far (.mclk(mclk), .line_req(line_req), .pullup_req(stim[5]), .dp(dp), .dm(dm),
      .remote_pullup_sense(rsense));

   always #4 mclk = ~mclk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Role-gated bits read zero in the other role
   function automatic logic [15:0] st_exp(input logic [5:0] s);
      return {10'h000, s[5], s[0] & s[4], ~s[0] & s[3], s[0] & s[2], ~s[0] & s[1], s[0]};
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait on pready; the request is held until it is seen
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v,
                      output logic [31:0] rd, output logic er);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= v;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         finish_test();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      apb(1'b1, a, v, d, e);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, d, e);
      chk(d & m, exp);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic pulse_timer();
      tmo <= 1'b1;
      @(posedge mclk);
      tmo <= 1'b0;
   endtask

   initial begin
      mclk = 1'b0;
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      tmo = 1'b0;
      stim = 6'h05;
      line_req = 2'h0;
      waitc(6);
      rstn <= 1'b1;
      rdchk(A_ST, 32'hFFFF_FFFF, 32'h0000_0005);
      rdchk(A_ER, 32'hFFFF_FFFF, 32'h0);
      $display("test reset done");
      // Remote detection is blind for the pull-up wait after reset
      waitc(24);
      wr(A_EW, 32'hFFFF);
      for (i = 0; i < 16; i++) begin
         prev = st_exp(stim);
         r = xs();
         stim <= r[5:0];
         cur = st_exp(r[5:0]);
         chg = prev[5:0] ^ cur[5:0];
         waitc(6);
         rdchk(A_ST, 32'hFFFF_FFFF, {16'h0, cur});
         rdchk(A_ER, 32'h3F, {26'h0, chg});
         w = xs();
         wr(A_EW, w);
         rdchk(A_ER, 32'h3F, {26'h0, chg & ~w[5:0]});
         wr(A_EW, 32'hFFFF);
      end
      $display("test status done");
      apb(1'b1, A_ST, 32'hFFFF, d, e);
      chk({31'h0, e}, 32'h1);
      rdchk(A_ST, 32'hFFFF_FFFF, {16'h0, cur});
      apb(1'b0, A_EW, 32'h0, d, e);
      chk({31'h0, e}, 32'h1);
      apb(1'b0, 12'h0F0, 32'h0, d, e);
      chk({e, d[30:0]}, 32'h8000_0000);
      pulse_timer();
      rdchk(A_ER, 32'h400, 32'h400);
      wr(A_EW, 32'hFFFF_F800);
      rdchk(A_ER, 32'hFFFF_FC00, 32'h400);
      apb(1'b0, A_IS, 32'h0, d, e);
      wr(A_MK, 32'h0);
      pulse_timer();
      waitc(3);
      chk({31'h0, irq}, 32'h0);
      wr(A_MK, 32'h400);
      waitc(2);
      chk({31'h0, irq}, 32'h1);
      rdchk(A_IS, 32'h400, 32'h400);
      waitc(2);
      chk({31'h0, irq}, 32'h0);
      $display("test timer irq done");
      line_req <= 2'h2;
      waitc(30);
      rdchk(A_ST, 32'h200, 32'h0);
      waitc(30);
      rdchk(A_ST, 32'h200, 32'h200);
      rdchk(A_ER, 32'h200, 32'h200);
      line_req <= 2'h0;
      waitc(5);
      rdchk(A_ST, 32'h200, 32'h0);
      wr(A_EW, 32'hFFFF);
      waitc(30);
      rdchk(A_ER, 32'hC0, 32'h0);
      waitc(50);
      rdchk(A_ER, 32'hC0, 32'h40);
      line_req <= 2'h1;
      waitc(6);
      rdchk(A_ER, 32'h80, 32'h80);
      $display("test line done");
      wr(A_CT, 32'h200);
      stim <= 6'h00;
      waitc(6);
      wr(A_EW, 32'hFFFF);
      stim <= 6'h08;
      waitc(6);
      rdchk(A_ER, 32'h100, 32'h100);
      wr(A_CT, 32'h0);
      wr(A_EW, 32'hFFFF);
      line_req <= 2'h0;
      waitc(6);
      rdchk(A_ER, 32'h100, 32'h100);
      $display("test session request done");
      wr(A_CT, 32'h1);
      waitc(3);
      chk({31'h0, pu_on}, 32'h1);
      stim <= 6'h28;
      waitc(6);
      rdchk(A_ST, 32'h20, 32'h0);
      wr(A_CT, 32'h0);
      rdchk(A_ST, 32'h20, 32'h0);
      waitc(30);
      rdchk(A_ST, 32'h20, 32'h20);
      $display("test pull-up done");
      finish_test();
   end
endmodule
`default_nettype wire

// ---- usbp_sync.sv ----
// Two-flop synchroniser for the asynchronous port inputs
`timescale 1ns/1ps
`default_nettype none
module usbp_sync
   import usbp_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic [8:0] d_async,
   output logic      [8:0] d_sync
);

   typedef struct packed {
      logic [8:0] meta;
      logic [8:0] stable;
   } usbp_sync_t;

   usbp_sync_t s;
   usbp_sync_t next_s;

   always_comb begin
      next_s.meta   = d_async;
      next_s.stable = s.meta;
   end

   // Reset to idle levels (ID high, below session end, line in J) so no false change event
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s <= {9'h091, 9'h091};
      end else begin
         s <= next_s;
      end
   end

   assign d_sync = s.stable;

endmodule
`default_nettype wire
